// ### hbk_brake_io.sv
// holding brake sequencer with read-only i/o status words
// assumes pins are asynchronous; op_state and standstill come from the drive fsm
// register port: rd_addr/rd_data read, wr_en/wr_addr/wr_data write, 1-cycle latency

// What this block does
// - combined word: inputs bits 0-3, outputs 8-9
// - status bits mirror live signal levels
// - input word: inputs in bits 0-3
// - output word: outputs in bits 0-1
// - safety word: channel a bit0, b bit1
// - safe torque off while enabled: disable, error 1300
// - enabled limit switch triggered raises error
// - power stage enabled: release brake automatically
// - operation enabled only after release delay, or at once while manually applied
// - power stage disabled: apply brake automatically
// - keep current during apply delay unless sto trips
// - manual release only in states 3,4,9
// - manual apply only at standstill
// - enable while manually applied keeps brake applied
// - manual apply beats every release
// - brake mode 0 auto,1 release,2 apply; reset auto
module hbk_brake_io
   import hbk_pkg::*;
#(
   parameter int REL_DELAY_US = 100,
   parameter int APP_DELAY_US = 100
) (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire hbk_pins_t             pins,
   input  wire logic                  lim_pos_en,
   input  wire logic                  lim_neg_en,
   input  wire logic                  power_enable_req,
   input  wire logic [3:0]            op_state,
   input  wire logic                  standstill,
   input  wire logic [HBK_DELAY_US_W-1:0] rel_delay_us,
   input  wire logic [HBK_DELAY_US_W-1:0] app_delay_us,
   input  wire logic                  nameplate_valid,
   input  wire logic                  wr_en,
   input  wire logic [15:0]           wr_addr,
   input  wire logic [15:0]           wr_data,
   input  wire logic [15:0]           rd_addr,
   output logic      [15:0]           rd_data,
   output logic                       brake_release,
   output logic                       motor_current,
   output logic                       op_enable_allowed,
   output logic                       error_active,
   output logic      [15:0]           error_code
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   hbk_pins_t pins_meta_q;
   hbk_pins_t pins_sync_q;

   always_ff @(posedge clock) begin
      pins_meta_q <= pins;
      pins_sync_q <= pins_meta_q;
   end

   // ****************************************************************
   // status words
   // ****************************************************************
   wire logic [15:0] io_combined_w = {6'h00, pins_sync_q.outputs, 4'h0, pins_sync_q.inputs};
   wire logic [15:0] input_w       = {12'h000, pins_sync_q.inputs};
   wire logic [15:0] output_w      = {14'h0000, pins_sync_q.outputs};
   wire logic [15:0] safety_w      = {14'h0000, pins_sync_q.safety_channel_b, pins_sync_q.safety_channel_a};

   // ****************************************************************
   // brake mode register
   // ****************************************************************
   hbk_mode_t mode_q;
   wire logic mode_wr   = wr_en && (wr_addr == HBK_OFS_BRAKE_MODE);
   wire logic rel_ok    = (op_state == HBK_OPST_SWDIS) || (op_state == HBK_OPST_READY)
                          || (op_state == HBK_OPST_FAULT);
   // once applied, a direct jump to release is refused; host must pass through auto
   wire logic take_auto = mode_wr && (wr_data[1:0] == HBK_MODE_AUTO);
   wire logic take_rel  = mode_wr && (wr_data[1:0] == HBK_MODE_RELEASE) && rel_ok
                          && (mode_q != HBK_MODE_APPLY);
   wire logic take_app  = mode_wr && (wr_data[1:0] == HBK_MODE_APPLY) && standstill;

   always_ff @(posedge clock) begin
      if (rst) begin
         mode_q <= HBK_MODE_AUTO;
      end else if (take_auto) begin
         mode_q <= HBK_MODE_AUTO;
      end else if (take_rel) begin
         mode_q <= HBK_MODE_RELEASE;
      end else if (take_app) begin
         mode_q <= HBK_MODE_APPLY;
      end
   end

   // ****************************************************************
   // faults
   // ****************************************************************
   wire logic sto_trip   = !(pins_sync_q.safety_channel_a && pins_sync_q.safety_channel_b);
   wire logic limit_trip = (lim_pos_en && pins_sync_q.lim_pos) || (lim_neg_en && pins_sync_q.lim_neg);
   logic       stage_on_q;
   logic [15:0] err_q;
   logic        err_act_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         err_q     <= HBK_ERR_NONE;
         err_act_q <= 1'b0;
      end else if (sto_trip && stage_on_q) begin
         err_q     <= HBK_ERR_STO;
         err_act_q <= 1'b1;
      end else if (limit_trip) begin
         err_q     <= HBK_ERR_LIMIT;
         err_act_q <= 1'b1;
      end else if (!power_enable_req && !sto_trip) begin
         // fault clears when the drive withdraws enable and no sto or limit trip is active
         err_act_q <= 1'b0;
      end
   end

   // sto removes torque at once; it does not wait for the apply delay
   wire logic stage_req = power_enable_req && !sto_trip && !err_act_q;

   // ****************************************************************
   // delay counter
   // ****************************************************************
   logic [HBK_CNT_W-1:0] cnt_q;
   logic                 cnt_load;
   logic [HBK_CNT_W-1:0] cnt_init;
   wire logic            cnt_done = (cnt_q == '0);
   wire logic [HBK_DELAY_US_W-1:0] rel_us = nameplate_valid ? rel_delay_us
                                          : HBK_DELAY_US_W'(REL_DELAY_US);
   wire logic [HBK_DELAY_US_W-1:0] app_us = nameplate_valid ? app_delay_us
                                          : HBK_DELAY_US_W'(APP_DELAY_US);
   wire logic [HBK_CNT_W-1:0] rel_cyc = HBK_CNT_W'(rel_us * HBK_CNT_W'(HBK_CYC_PER_US));
   wire logic [HBK_CNT_W-1:0] app_cyc = HBK_CNT_W'(app_us * HBK_CNT_W'(HBK_CYC_PER_US));

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (cnt_load) begin
         cnt_q <= cnt_init;
      end else if (!cnt_done) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // ****************************************************************
   // brake sequencer
   // ****************************************************************
   hbk_state_t st_q;
   hbk_state_t st_d;
   wire logic  man_apply = (mode_q == HBK_MODE_APPLY);
   wire logic  man_rel   = (mode_q == HBK_MODE_RELEASE) && !stage_req;

   always_comb begin
      st_d     = st_q;
      cnt_load = 1'b0;
      cnt_init = '0;
      unique case (st_q)
         HBK_ST_HELD: begin
            if (stage_req && !man_apply) begin
               st_d     = HBK_ST_RELEASING;
               cnt_load = 1'b1;
               cnt_init = rel_cyc;
            end
         end
         HBK_ST_RELEASING: begin
            if (!stage_req || man_apply) begin
               st_d     = HBK_ST_APPLYING;
               cnt_load = 1'b1;
               cnt_init = app_cyc;
            end else if (cnt_done) begin
               st_d = HBK_ST_OPEN;
            end
         end
         HBK_ST_OPEN: begin
            if (!stage_req || man_apply) begin
               st_d     = HBK_ST_APPLYING;
               cnt_load = 1'b1;
               cnt_init = app_cyc;
            end
         end
         HBK_ST_APPLYING: begin
            if (cnt_done) begin
               st_d = HBK_ST_HELD;
            end
         end
      endcase
   end

   wire logic stage_on_d = stage_req || (st_d == HBK_ST_APPLYING && !sto_trip);
   wire logic brake_d    = !man_apply && ((st_d == HBK_ST_RELEASING) || (st_d == HBK_ST_OPEN)
                           || man_rel);

   always_ff @(posedge clock) begin
      if (rst) begin
         st_q              <= HBK_ST_HELD;
         stage_on_q        <= 1'b0;
         brake_release     <= 1'b0;
         op_enable_allowed <= 1'b0;
      end else begin
         st_q              <= st_d;
         stage_on_q        <= stage_on_d;
         brake_release     <= brake_d;
         op_enable_allowed <= (st_d == HBK_ST_OPEN) || (st_d == HBK_ST_HELD && stage_req
                              && man_apply);
      end
   end

   assign motor_current = stage_on_q;

   // ****************************************************************
   // register read port
   // ****************************************************************
   logic [15:0] rd_mux;

   always_comb begin
      unique case (rd_addr)
         HBK_OFS_IO_COMBINED: rd_mux = io_combined_w;
         HBK_OFS_INPUT:       rd_mux = input_w;
         HBK_OFS_OUTPUT:      rd_mux = output_w;
         HBK_OFS_SAFETY:      rd_mux = safety_w;
         HBK_OFS_BRAKE_MODE:  rd_mux = {14'h0000, mode_q};
         default:             rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rd_data <= 16'h0000;
      end else begin
         rd_data <= rd_mux;
      end
   end

   assign error_active = err_act_q;
   assign error_code   = err_q;

endmodule

// ### hbk_pkg.sv
// package for the holding brake sequencer and i/o status block
// assumes one 125 MHz clock; nameplate delays arrive in microseconds
package hbk_pkg;

   // ****************************************************************
   // register offsets (fieldbus parameter addresses)
   // ****************************************************************
   localparam logic [15:0] HBK_OFS_IO_COMBINED = 16'h0802;
   localparam logic [15:0] HBK_OFS_INPUT       = 16'h081e;
   localparam logic [15:0] HBK_OFS_OUTPUT      = 16'h0820;
   localparam logic [15:0] HBK_OFS_SAFETY      = 16'h084c;
   localparam logic [15:0] HBK_OFS_BRAKE_MODE  = 16'h0814;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int HBK_POS_IN_LO  = 0;
   localparam int HBK_POS_OUT_HI = 8;
   localparam int HBK_POS_SAFETY_CHANNEL_A  = 0;
   localparam int HBK_POS_SAFETY_CHANNEL_B  = 1;

   // ****************************************************************
   // codes and reset values
   // ****************************************************************
   localparam logic [15:0] HBK_ERR_STO      = 16'd1300;
   localparam logic [15:0] HBK_ERR_LIMIT    = 16'd1;
   localparam logic [15:0] HBK_ERR_NONE     = 16'h0000;
   localparam logic [3:0]  HBK_OPST_SWDIS   = 4'h3;
   localparam logic [3:0]  HBK_OPST_READY   = 4'h4;
   localparam logic [3:0]  HBK_OPST_OPEN    = 4'h6;
   localparam logic [3:0]  HBK_OPST_FAULT   = 4'h9;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int HBK_CLK_MHZ        = 125;
   localparam int HBK_CYC_PER_US     = HBK_CLK_MHZ;
   localparam int HBK_DELAY_US_W     = 16;
   localparam int HBK_CNT_W          = 24;

   typedef enum logic [1:0] {
      HBK_MODE_AUTO    = 2'b00,
      HBK_MODE_RELEASE = 2'b01,
      HBK_MODE_APPLY   = 2'b10
   } hbk_mode_t;

   typedef enum logic [1:0] {
      HBK_ST_HELD      = 2'b00,
      HBK_ST_RELEASING = 2'b01,
      HBK_ST_OPEN      = 2'b10,
      HBK_ST_APPLYING  = 2'b11
   } hbk_state_t;

   typedef struct packed {
      logic [3:0] inputs;
      logic [1:0] outputs;
      logic       safety_channel_a;
      logic       safety_channel_b;
      logic       lim_pos;
      logic       lim_neg;
   } hbk_pins_t;

endpackage

// ### hbk_brake_io_props.sv
// checker on the brake sequencer's ports
// assumes nameplate_valid low, so parameter delays apply
module hbk_brake_io_props
   import hbk_pkg::*;
#(
   parameter int REL_DELAY_US = 100,
   parameter int APP_DELAY_US = 100
) (
   input wire logic                      clock,
   input wire logic                      rst,
   input wire hbk_pins_t                 pins,
   input wire logic                      power_enable_req,
   input wire logic [15:0]               rd_addr,
   input wire logic [15:0]               rd_data,
   input wire logic                      brake_release,
   input wire logic                      motor_current,
   input wire logic                      op_enable_allowed,
   input wire logic                      error_active,
   input wire logic [15:0]               error_code
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // current-on age, checks the release wait
   // ****
   localparam int REL_CYC = REL_DELAY_US * HBK_CYC_PER_US;
   localparam int APP_MAX = APP_DELAY_US * HBK_CYC_PER_US + 4;
   logic [HBK_CNT_W-1:0] on_q;
   logic [HBK_CNT_W-1:0] on_d;
   assign on_d = motor_current ? on_q + 1'b1 : '0;
   always_ff @(posedge clock) on_q <= rst ? '0 : on_d;

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // a manually applied brake grants operation without any release wait
   op_after_rel_a: assert property ($rose(op_enable_allowed) && brake_release
      |-> on_q >= REL_CYC)
      else $error("operation enabled before release delay");
   op_needs_cur_a: assert property (op_enable_allowed |-> motor_current)
      else $error("operation enabled without current");
   auto_rel_a: assert property ($rose(power_enable_req) && !motor_current && pins.safety_channel_a
      && pins.safety_channel_b && !error_active |=> motor_current) else $error("no current on enable");
   auto_apply_a: assert property ($fell(power_enable_req) && motor_current && !error_active
      |=> !brake_release && !op_enable_allowed) else $error("brake not applied");
   cur_hold_a: assert property ($fell(power_enable_req) && motor_current && !error_active
      && brake_release |=> motor_current [*8]) else $error("current dropped in apply delay");
   cur_drop_a: assert property ($fell(power_enable_req) |-> ##[1:APP_MAX] !motor_current)
      else $error("current kept past apply delay");
   sto_trip_a: assert property ($fell(pins.safety_channel_a) && motor_current
      |-> ##[1:6] (error_code == HBK_ERR_STO && !motor_current)) else $error("no sto trip");
   in_word_a: assert property ($past(rd_addr) == HBK_OFS_INPUT |-> rd_data[15:4] == '0)
      else $error("input word upper bits set");
   out_word_a: assert property ($past(rd_addr) == HBK_OFS_OUTPUT |-> rd_data[15:2] == '0)
      else $error("output word upper bits set");

   cover property ($rose(op_enable_allowed));
   cover property (error_code == HBK_ERR_STO);
   cover property (brake_release && !motor_current);
endmodule

bind hbk_brake_io hbk_brake_io_props #(.REL_DELAY_US(REL_DELAY_US), .APP_DELAY_US(APP_DELAY_US))
   u_props (.clock(clock), .rst(rst), .pins(pins), .power_enable_req(power_enable_req),
   .rd_addr(rd_addr), .rd_data(rd_data), .brake_release(brake_release),
   .motor_current(motor_current), .op_enable_allowed(op_enable_allowed),
   .error_active(error_active), .error_code(error_code));

// ### hbk_pins_model.sv
// pin side of the drive: digital i/o, safety channels, limit switches
// assumes the bench changes levels just after a clock edge
module hbk_pins_model
   import hbk_pkg::*;
(
   input  wire logic [3:0] di,
   input  wire logic [1:0] dq,
   input  wire logic       cut_a,
   input  wire logic       cut_b,
   input  wire logic       lim_hit,
   output hbk_pins_t       pins
);
   timeunit 1ns;
   timeprecision 100ps;
   // healthy safety channels sit high; a cut wire pulls low
   assign pins = '{inputs: di, outputs: dq, safety_channel_a: !cut_a, safety_channel_b: !cut_b,
                   lim_pos: lim_hit, lim_neg: lim_hit};
endmodule

// ### holding_brake_io_status_tb_top.sv
// bench for the brake sequencer and status words
// assumes the checker is bound by its own file
module holding_brake_io_status_tb_top;
   import hbk_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DLY = 125;
   logic clock, rst, req, standstill, wr_en, lim_en, cut_a, cut_b, lim;
   logic [3:0] op_state, di;
   logic [1:0] dq;
   logic [15:0] wr_addr, wr_data, rd_addr, rd_data, error_code;
   logic brake_release, motor_current, op_enable_allowed, error_active;
   hbk_pins_t pins;
   int fails, n_compared, n;

   hbk_pins_model u_pins (.di(di), .dq(dq), .cut_a(cut_a), .cut_b(cut_b), .lim_hit(lim),
      .pins(pins));
   hbk_brake_io #(.REL_DELAY_US(1), .APP_DELAY_US(1)) dut (.clock(clock), .rst(rst),
      .pins(pins), .lim_pos_en(lim_en), .lim_neg_en(lim_en), .power_enable_req(req),
      .op_state(op_state), .standstill(standstill), .rel_delay_us(16'h0001),
      .app_delay_us(16'h0001), .nameplate_valid(1'b0), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .brake_release(brake_release),
      .motor_current(motor_current), .op_enable_allowed(op_enable_allowed),
      .error_active(error_active), .error_code(error_code));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ****
   // tasks
   // ****
   function automatic logic [15:0] w(input logic x);
      return {15'h0000, x};
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // trailing idle cycle keeps back-to-back writes from re-raising wr_en at once
   task automatic wr(input logic [15:0] d);
      wr_en = 1'b1;
      wr_addr = HBK_OFS_BRAKE_MODE;
      wr_data = d;
      tick(1);
      wr_en = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [15:0] a, exp, input string what);
      rd_addr = a;
      tick(1);
      check(what, rd_data, exp);
   endtask
   task automatic await(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 400) begin
         tick(1);
         n++;
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      print_verdict();
   end

   // ****
   // tests
   // ****
   initial begin
      {rst, req, standstill} = 3'h5;
      {wr_en, lim_en, cut_a, cut_b, lim} = 5'h00;
      {di, dq, wr_addr, wr_data, rd_addr} = '0;
      op_state = HBK_OPST_SWDIS;
      tick(16);
      rst = 1'b0;
      rd(HBK_OFS_BRAKE_MODE, 16'h0000, "mode_rst");
      for (int i = 0; i < 4; i++) begin
         di = 4'h1 << i;
         dq = 2'(i);
         cut_a = !i[0];
         cut_b = !i[1];
         tick(4);
         rd(HBK_OFS_IO_COMBINED, {6'h00, dq, 4'h0, di}, "io");
         rd(HBK_OFS_INPUT, {12'h000, di}, "in");
         rd(HBK_OFS_OUTPUT, {14'h0000, dq}, "out");
         rd(HBK_OFS_SAFETY, {14'h0000, 2'(i)}, "sto");
      end
      $display("status test done");
      op_state = HBK_OPST_READY;
      req = 1'b1;
      tick(1);
      check("cur_on", w(motor_current), 16'h0001);
      check("rel_on", w(brake_release), 16'h0001);
      await(op_enable_allowed, 1'b1);
      check("rel_wait", w(n >= DLY && n <= DLY + 4), 16'h0001);
      op_state = HBK_OPST_OPEN;
      wr(16'h0001);
      rd(HBK_OFS_BRAKE_MODE, 16'h0000, "rel_refused");
      req = 1'b0;
      tick(1);
      check("apply", w(brake_release), 16'h0000);
      check("cur_held", w(motor_current), 16'h0001);
      await(motor_current, 1'b0);
      check("app_wait", w(n >= DLY - 2), 16'h0001);
      $display("auto test done");
      for (int i = 0; i < 3; i++) begin
         op_state = (i == 0) ? HBK_OPST_SWDIS : (i == 1) ? HBK_OPST_READY : HBK_OPST_FAULT;
         wr(16'h0001);
         tick(2);
         check("man_rel", w(brake_release), 16'h0001);
         wr(16'h0000);
         tick(2);
         check("auto_back", w(brake_release), 16'h0000);
      end
      wr(16'h0001);
      standstill = 1'b0;
      wr(16'h0002);
      rd(HBK_OFS_BRAKE_MODE, 16'h0001, "app_refused");
      standstill = 1'b1;
      wr(16'h0002);
      tick(2);
      rd(HBK_OFS_BRAKE_MODE, 16'h0002, "app_taken");
      check("app_wins", w(brake_release), 16'h0000);
      wr(16'h0001);
      rd(HBK_OFS_BRAKE_MODE, 16'h0002, "app_kept");
      req = 1'b1;
      tick(3);
      check("en_held", w(brake_release), 16'h0000);
      check("en_cur", w(motor_current), 16'h0001);
      req = 1'b0;
      wr(16'h0000);
      await(motor_current, 1'b0);
      $display("manual test done");
      req = 1'b1;
      await(op_enable_allowed, 1'b1);
      cut_a = 1'b1;
      tick(6);
      check("sto_off", w(motor_current), 16'h0000);
      check("sto_code", error_code, HBK_ERR_STO);
      req = 1'b0; // withdraw enable so the sto fault clears
      cut_a = 1'b0;
      tick(6);
      check("sto_clear", w(error_active), 16'h0000);
      req = 1'b1;
      lim_en = 1'b1;
      lim = 1'b1;
      tick(6);
      check("lim_err", w(error_active), 16'h0001);
      check("lim_code", error_code, HBK_ERR_LIMIT);
      $display("fault test done");
      print_verdict();
   end
endmodule
